// ===== framer_irq_loopback_ctrl.sv
// Operation
// - interrupt pin goes low while any enabled interrupt is pending anywhere
// - summary register has one pending bit per framer, offset depends on mode
// - e1 first source register bit layout for receive side blocks
// - e1 second source register bit layout for transmit side blocks
// - t1 first source register bit layout for receive side blocks
// - t1 second source register bit layout for transmit side blocks
// - t1 second source register bit 6 shows pending parity error
// - a source bit reads one while its block has an enabled pending interrupt
// - line loopback sends receive clock and data to the line transmit pins
// - line loopback may bypass the receive jitter attenuator
// - digital loopback feeds line transmit back into receive, ignoring line input
// - payload loopback per channel, only while payload control enable is set
// - clock master receive uses elastic store data for payload loopback
// - selected transmit slots take received slots, others stay unchanged
// - rising edges of five clocks reported in the activity register
// - soft reset bit resets only its own framer to defaults
// - device starts in t1 mode, writing zero to mode bit selects e1
// - jitter divisors reset to 2F, transmit attenuation on, locked to clock b
// - line interface resets to nrz, rising receive sample, falling transmit update
//
// Local design decision: the Wishbone slave port.
module framer_irq_loopback_ctrl
   import framer_ctrl_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [12:2] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   output logic o_irq_n,
   output logic o_t1_e1_select,
   input wire logic [NUM_FRAMERS*8-1:0] i_src_rx,
   input wire logic [NUM_FRAMERS*8-1:0] i_src_tx,
   input wire logic i_crystal_clock,
   input wire logic [NUM_FRAMERS-1:0] i_tx_sys_clock_a,
   input wire logic [NUM_FRAMERS-1:0] i_tx_sys_clock_b,
   input wire logic [NUM_FRAMERS-1:0] i_rx_sys_clock,
   input wire logic [NUM_FRAMERS-1:0] i_line_rx_clock,
   input wire logic [NUM_FRAMERS-1:0] i_line_rx_data,
   input wire logic [NUM_FRAMERS-1:0] i_rja_clock,
   input wire logic [NUM_FRAMERS-1:0] i_rja_data,
   input wire logic [NUM_FRAMERS-1:0] i_core_tx_clock,
   input wire logic [NUM_FRAMERS-1:0] i_core_tx_data,
   input wire logic [NUM_FRAMERS*5-1:0] i_tx_slot,
   input wire logic [NUM_FRAMERS*8-1:0] i_es_rx_pay,
   input wire logic [NUM_FRAMERS*8-1:0] i_rx_pay,
   input wire logic [NUM_FRAMERS*8-1:0] i_core_tx_pay,
   output logic [NUM_FRAMERS-1:0] o_line_tx_clock,
   output logic [NUM_FRAMERS-1:0] o_line_tx_data,
   output logic [NUM_FRAMERS-1:0] o_core_rx_clock,
   output logic [NUM_FRAMERS-1:0] o_core_rx_data,
   output logic [NUM_FRAMERS*8-1:0] o_tx_pay,
   output logic [NUM_FRAMERS*8-1:0] o_ja_n1,
   output logic [NUM_FRAMERS*8-1:0] o_ja_n2,
   output logic [NUM_FRAMERS*CFG_WIDTH-1:0] o_line_cfg,
   output logic [NUM_FRAMERS-1:0] o_framer_reset
);

   // register index decode for the current mode
   function automatic reg_sel_type decode_reg(input logic t1_mode, input logic [6:0] off);
      reg_sel_type sel;
      sel = SEL_NONE;
      if (off[6:5] == TX_PAYLOAD_CONTROL_BASE_OFF[6:5]) begin
         sel = SEL_TX_PAYLOAD_CONTROL;
      end else if (off == JA_N1_OFF) begin
         sel = SEL_N1;
      end else if (off == JA_N2_OFF) begin
         sel = SEL_N2;
      end else if (off == LINE_CFG_OFF) begin
         sel = SEL_CFG;
      end else if (t1_mode) begin
         unique case (off)
            T1_SRC_RX_OFF: sel = SEL_SRC_RX;
            T1_SRC_TX_OFF: sel = SEL_SRC_TX;
            T1_LOOP_OFF: sel = SEL_LOOP;
            T1_SOFT_RESET_OFF: sel = SEL_SOFT;
            T1_SUMMARY_OFF: sel = SEL_SUMMARY;
            T1_ACTIVITY_OFF: sel = SEL_ACTIVITY;
            T1_PAYLOAD_CTRL_ENABLE_OFF: sel = SEL_PAYLOAD_CTRL_ENABLE;
            default: sel = SEL_NONE;
         endcase
      end else begin
         unique case (off)
            E1_SRC_RX_OFF: sel = SEL_SRC_RX;
            E1_SRC_TX_OFF: sel = SEL_SRC_TX;
            E1_LOOP_OFF: sel = SEL_LOOP;
            E1_SOFT_RESET_OFF: sel = SEL_SOFT;
            E1_SUMMARY_OFF: sel = SEL_SUMMARY;
            E1_ACTIVITY_OFF: sel = SEL_ACTIVITY;
            E1_PAYLOAD_CTRL_ENABLE_OFF: sel = SEL_PAYLOAD_CTRL_ENABLE;
            default: sel = SEL_NONE;
         endcase
      end
      return sel;
   endfunction : decode_reg

   // source bits that exist in the current mode
   function automatic logic [7:0] src_mask(input logic t1_mode, input logic tx_side);
      logic [7:0] m;
      m = tx_side ? E1_SRC_TX_MASK : E1_SRC_RX_MASK;
      if (t1_mode) begin
         m = tx_side ? T1_SRC_TX_MASK : T1_SRC_RX_MASK;
      end
      return m;
   endfunction : src_mask

   logic t1_mode;
   logic [7:0] src_rx [NUM_FRAMERS];
   logic [7:0] src_tx [NUM_FRAMERS];
   logic [NUM_FRAMERS-1:0] summary;
   logic [NUM_FRAMERS-1:0] line_loop;
   logic [NUM_FRAMERS-1:0] digital_loop;
   logic [NUM_FRAMERS-1:0] rja_bypass;
   logic [NUM_FRAMERS-1:0] payload_ctrl_enable;
   logic [NUM_CHANNELS-1:0] tx_payload_control_loop [NUM_FRAMERS];
   logic [7:0] ja_n1 [NUM_FRAMERS];
   logic [7:0] ja_n2 [NUM_FRAMERS];
   logic [CFG_WIDTH-1:0] line_cfg [NUM_FRAMERS];
   logic [NUM_FRAMERS-1:0] soft_reset;
   logic [ACT_WIDTH-1:0] activity [NUM_FRAMERS];
   logic [ACT_WIDTH-1:0] act_clear [NUM_FRAMERS];
   logic [ACT_WIDTH-1:0] rx_levels [NUM_FRAMERS];
   logic [NUM_FRAMERS-1:0] rx_data_meta;
   logic [NUM_FRAMERS-1:0] rx_data_sync;
   logic [NUM_FRAMERS-1:0] payload_sel;
   logic [2:0] acc_framer;
   logic [6:0] acc_off;
   logic acc_global;
   reg_sel_type acc_sel;
   logic bus_req;
   logic wr_commit;
   logic rd_commit;
   logic [7:0] next_rd_data;

   // bus access decode
   assign bus_req = i_wb_cyc & i_wb_stb;
   assign acc_global = i_wb_adr[IDX_GLOBAL_BIT + 2];
   assign acc_framer = i_wb_adr[11:9];
   assign acc_off = i_wb_adr[8:2];
   assign acc_sel = acc_global ? SEL_NONE : decode_reg(t1_mode, acc_off);
   assign wr_commit = bus_req & o_wb_ack & i_wb_we & i_wb_sel[0];
   assign rd_commit = bus_req & o_wb_ack & ~i_wb_we;

   // ack one cycle after the request, dropped the cycle after
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_wb_ack <= 1'b0;
      end else begin
         o_wb_ack <= bus_req & ~o_wb_ack;
      end
   end

   // read data mux, unmapped reads give zero
   always_comb begin
      next_rd_data = 8'h00;
      if (acc_global) begin
         if (i_wb_adr[12:2] == GLOBAL_MODE_IDX) begin
            next_rd_data[MODE_T1_BIT] = t1_mode;
         end
      end else begin
         unique case (acc_sel)
            SEL_SRC_RX: next_rd_data = src_rx[acc_framer];
            SEL_SRC_TX: next_rd_data = src_tx[acc_framer];
            SEL_SUMMARY: next_rd_data = summary;
            SEL_ACTIVITY: next_rd_data[ACT_WIDTH-1:0] = activity[acc_framer];
            SEL_SOFT: next_rd_data[SOFT_RESET_BIT] = soft_reset[acc_framer];
            SEL_PAYLOAD_CTRL_ENABLE: next_rd_data[PAYLOAD_CTRL_ENABLE_BIT] = payload_ctrl_enable[acc_framer];
            SEL_TX_PAYLOAD_CONTROL: next_rd_data[TX_PAYLOAD_CONTROL_LOOP_BIT] = tx_payload_control_loop[acc_framer][acc_off[4:0]];
            SEL_N1: next_rd_data = ja_n1[acc_framer];
            SEL_N2: next_rd_data = ja_n2[acc_framer];
            SEL_CFG: next_rd_data[CFG_WIDTH-1:0] = line_cfg[acc_framer];
            SEL_LOOP: begin
               next_rd_data[LOOP_LINE_BIT] = line_loop[acc_framer];
               next_rd_data[LOOP_DIGITAL_BIT] = digital_loop[acc_framer];
               next_rd_data[LOOP_RJA_BYPASS_BIT] = rja_bypass[acc_framer];
            end
            SEL_NONE: next_rd_data = 8'h00;
         endcase
      end
   end

   // read data register, captured with the ack
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_wb_dat <= 32'h0000_0000;
      end else if (bus_req & ~o_wb_ack & ~i_wb_we) begin
         o_wb_dat <= {24'h00_0000, next_rd_data};
      end
   end

   // global mode bit, t1 after reset
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         t1_mode <= MODE_RESET;
      end else if (wr_commit && i_wb_adr[12:2] == GLOBAL_MODE_IDX) begin
         t1_mode <= i_wb_dat[MODE_T1_BIT];
      end
   end

   // interrupt sources, summary and pin
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         for (int f = 0; f < NUM_FRAMERS; f++) begin
            src_rx[f] <= 8'h00;
            src_tx[f] <= 8'h00;
         end
         summary <= '0;
         o_irq_n <= 1'b1;
      end else begin
         for (int f = 0; f < NUM_FRAMERS; f++) begin
            src_rx[f] <= i_src_rx[f*8 +: 8] & src_mask(t1_mode, 1'b0);
            src_tx[f] <= i_src_tx[f*8 +: 8] & src_mask(t1_mode, 1'b1);
            summary[f] <= |{src_rx[f], src_tx[f]};
         end
         o_irq_n <= ~(|summary);
      end
   end

   // soft reset pulse per framer
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         soft_reset <= '0;
      end else begin
         for (int f = 0; f < NUM_FRAMERS; f++) begin
            soft_reset[f] <= wr_commit && acc_sel == SEL_SOFT && acc_framer == 3'(f) &&
                             i_wb_dat[SOFT_RESET_BIT];
         end
      end
   end

   // per framer control registers with defaults
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         for (int f = 0; f < NUM_FRAMERS; f++) begin
            line_loop[f] <= 1'b0;
            digital_loop[f] <= 1'b0;
            rja_bypass[f] <= 1'b0;
            payload_ctrl_enable[f] <= 1'b0;
            tx_payload_control_loop[f] <= '0;
            ja_n1[f] <= JA_DIV_RESET;
            ja_n2[f] <= JA_DIV_RESET;
            line_cfg[f] <= LINE_CFG_RESET;
         end
      end else begin
         for (int f = 0; f < NUM_FRAMERS; f++) begin
            if (soft_reset[f]) begin
               line_loop[f] <= 1'b0;
               digital_loop[f] <= 1'b0;
               rja_bypass[f] <= 1'b0;
               payload_ctrl_enable[f] <= 1'b0;
               tx_payload_control_loop[f] <= '0;
               ja_n1[f] <= JA_DIV_RESET;
               ja_n2[f] <= JA_DIV_RESET;
               line_cfg[f] <= LINE_CFG_RESET;
            end else if (wr_commit && acc_framer == 3'(f)) begin
               unique case (acc_sel)
                  SEL_LOOP: begin
                     line_loop[f] <= i_wb_dat[LOOP_LINE_BIT];
                     digital_loop[f] <= i_wb_dat[LOOP_DIGITAL_BIT];
                     rja_bypass[f] <= i_wb_dat[LOOP_RJA_BYPASS_BIT];
                  end
                  SEL_PAYLOAD_CTRL_ENABLE: payload_ctrl_enable[f] <= i_wb_dat[PAYLOAD_CTRL_ENABLE_BIT];
                  SEL_TX_PAYLOAD_CONTROL: tx_payload_control_loop[f][acc_off[4:0]] <= i_wb_dat[TX_PAYLOAD_CONTROL_LOOP_BIT];
                  SEL_N1: ja_n1[f] <= i_wb_dat[7:0];
                  SEL_N2: ja_n2[f] <= i_wb_dat[7:0];
                  SEL_CFG: line_cfg[f] <= i_wb_dat[CFG_WIDTH-1:0];
                  default: ;
               endcase
            end
         end
      end
   end

   // read of the activity register clears only the bits returned
   always_comb begin
      for (int f = 0; f < NUM_FRAMERS; f++) begin
         act_clear[f] = '0;
         if (rd_commit && acc_sel == SEL_ACTIVITY && acc_framer == 3'(f)) begin
            act_clear[f] = o_wb_dat[ACT_WIDTH-1:0];
         end
      end
   end

   // line receive data synchroniser
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         rx_data_meta <= '0;
         rx_data_sync <= '0;
      end else begin
         rx_data_meta <= i_line_rx_data;
         rx_data_sync <= rx_data_meta;
      end
   end

   // configuration and reset outputs, registered
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_t1_e1_select <= MODE_RESET;
         o_ja_n1 <= {NUM_FRAMERS{JA_DIV_RESET}};
         o_ja_n2 <= {NUM_FRAMERS{JA_DIV_RESET}};
         o_line_cfg <= {NUM_FRAMERS{LINE_CFG_RESET}};
         o_framer_reset <= '0;
      end else begin
         o_t1_e1_select <= t1_mode;
         for (int f = 0; f < NUM_FRAMERS; f++) begin
            o_ja_n1[f*8 +: 8] <= ja_n1[f];
            o_ja_n2[f*8 +: 8] <= ja_n2[f];
            o_line_cfg[f*CFG_WIDTH +: CFG_WIDTH] <= line_cfg[f];
         end
         o_framer_reset <= soft_reset;
      end
   end

   // per framer clock monitor and loopback paths
   for (genvar g = 0; g < NUM_FRAMERS; g++) begin : gen_framer
      assign payload_sel[g] = payload_ctrl_enable[g] & tx_payload_control_loop[g][i_tx_slot[g*5 +: 5]];

      clk_activity u_activity (
         .i_clk_sys(i_clk_sys),
         .i_reset(i_reset),
         .i_soft_reset(soft_reset[g]),
         .i_clocks({i_crystal_clock, i_tx_sys_clock_b[g], i_tx_sys_clock_a[g], i_rx_sys_clock[g],
                    i_line_rx_clock[g]}),
         .i_clear(act_clear[g]),
         .o_active(activity[g]),
         .o_levels(rx_levels[g])
      );

      framer_loopback u_loopback (
         .i_clk_sys(i_clk_sys),
         .i_reset(i_reset),
         .i_soft_reset(soft_reset[g]),
         .i_line_loop(line_loop[g]),
         .i_digital_loop(digital_loop[g]),
         .i_rja_bypass(rja_bypass[g]),
         .i_payload_sel(payload_sel[g]),
         .i_rx_clock_master(line_cfg[g][CFG_RX_CLOCK_MASTER_BIT]),
         .i_line_rx_clock(rx_levels[g][0]),
         .i_line_rx_data(rx_data_sync[g]),
         .i_rja_clock(i_rja_clock[g]),
         .i_rja_data(i_rja_data[g]),
         .i_core_tx_clock(i_core_tx_clock[g]),
         .i_core_tx_data(i_core_tx_data[g]),
         .i_es_rx_pay(i_es_rx_pay[g*8 +: 8]),
         .i_rx_pay(i_rx_pay[g*8 +: 8]),
         .i_core_tx_pay(i_core_tx_pay[g*8 +: 8]),
         .o_line_tx_clock(o_line_tx_clock[g]),
         .o_line_tx_data(o_line_tx_data[g]),
         .o_core_rx_clock(o_core_rx_clock[g]),
         .o_core_rx_data(o_core_rx_data[g]),
         .o_tx_pay(o_tx_pay[g*8 +: 8])
      );
   end

endmodule : framer_irq_loopback_ctrl

// ===== framer_ctrl_pkg.sv
package framer_ctrl_pkg;

   localparam int NUM_FRAMERS = 8;
   localparam int NUM_CHANNELS = 32;

   // register index layout: bit 10 selects global space, bits 9:7 the framer, 6:0 the offset
   localparam logic [10:0] GLOBAL_MODE_IDX = 11'h400;
   localparam int IDX_GLOBAL_BIT = 10;

   // offsets in e1 mode
   localparam logic [6:0] E1_SRC_RX_OFF = 7'h05;
   localparam logic [6:0] E1_SRC_TX_OFF = 7'h06;
   localparam logic [6:0] E1_LOOP_OFF = 7'h07;
   localparam logic [6:0] E1_SOFT_RESET_OFF = 7'h0A;
   localparam logic [6:0] E1_SUMMARY_OFF = 7'h0B;
   localparam logic [6:0] E1_ACTIVITY_OFF = 7'h0D;
   localparam logic [6:0] E1_PAYLOAD_CTRL_ENABLE_OFF = 7'h60;
   // offsets in t1/j1 mode
   localparam logic [6:0] T1_SRC_RX_OFF = 7'h08;
   localparam logic [6:0] T1_SRC_TX_OFF = 7'h09;
   localparam logic [6:0] T1_LOOP_OFF = 7'h0A;
   localparam logic [6:0] T1_SOFT_RESET_OFF = 7'h0D;
   localparam logic [6:0] T1_SUMMARY_OFF = 7'h0E;
   localparam logic [6:0] T1_ACTIVITY_OFF = 7'h27;
   localparam logic [6:0] T1_PAYLOAD_CTRL_ENABLE_OFF = 7'h30;
   // offsets common to both modes
   localparam logic [6:0] TX_PAYLOAD_CONTROL_BASE_OFF = 7'h40;
   localparam logic [6:0] JA_N1_OFF = 7'h78;
   localparam logic [6:0] JA_N2_OFF = 7'h79;
   localparam logic [6:0] LINE_CFG_OFF = 7'h7A;

   // field positions
   localparam int MODE_T1_BIT = 0;
   localparam int LOOP_DIGITAL_BIT = 2;
   localparam int LOOP_LINE_BIT = 4;
   localparam int LOOP_RJA_BYPASS_BIT = 5;
   localparam int SOFT_RESET_BIT = 0;
   localparam int PAYLOAD_CTRL_ENABLE_BIT = 0;
   localparam int TX_PAYLOAD_CONTROL_LOOP_BIT = 2;
   localparam int CFG_RX_SAMPLE_FALL_BIT = 0;
   localparam int CFG_TX_UPDATE_RISE_BIT = 1;
   localparam int CFG_TX_JA_DISABLE_BIT = 2;
   localparam int CFG_TX_JA_REF_A_BIT = 3;
   localparam int CFG_RX_CLOCK_MASTER_BIT = 4;
   localparam int CFG_WIDTH = 5;
   localparam int ACT_WIDTH = 5;

   // values after reset
   localparam logic MODE_RESET = 1'b1;
   localparam logic [7:0] JA_DIV_RESET = 8'h2F;
   localparam logic [CFG_WIDTH-1:0] LINE_CFG_RESET = 5'h00;

   // source bits that exist in each mode
   localparam logic [7:0] E1_SRC_RX_MASK = 8'hFF;
   localparam logic [7:0] E1_SRC_TX_MASK = 8'hBF;
   localparam logic [7:0] T1_SRC_RX_MASK = 8'hFF;
   localparam logic [7:0] T1_SRC_TX_MASK = 8'hFD;

   // hardware reset pin minimum width
   localparam int CLK_PERIOD_NS = 50;
   localparam int HW_RESET_MIN_NS = 100;
   localparam int HW_RESET_MIN_CYCLES = (HW_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum {SEL_NONE, SEL_SRC_RX, SEL_SRC_TX, SEL_LOOP, SEL_SOFT, SEL_SUMMARY, SEL_ACTIVITY,
                 SEL_PAYLOAD_CTRL_ENABLE, SEL_TX_PAYLOAD_CONTROL, SEL_N1, SEL_N2, SEL_CFG} reg_sel_type;

endpackage : framer_ctrl_pkg

// ===== clk_activity.sv
module clk_activity
   import framer_ctrl_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_soft_reset,
   input wire logic [ACT_WIDTH-1:0] i_clocks,
   input wire logic [ACT_WIDTH-1:0] i_clear,
   output logic [ACT_WIDTH-1:0] o_active,
   output logic [ACT_WIDTH-1:0] o_levels
);

   logic [ACT_WIDTH-1:0] meta;
   logic [ACT_WIDTH-1:0] prev;

   // two-stage synchroniser for the monitored clocks
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         meta <= '0;
         o_levels <= '0;
         prev <= '0;
      end else begin
         meta <= i_clocks;
         o_levels <= meta;
         prev <= o_levels;
      end
   end

   // sticky rise flags, a new rise beats the read clear
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_active <= '0;
      end else if (i_soft_reset) begin
         o_active <= '0;
      end else begin
         o_active <= (o_active & ~i_clear) | (o_levels & ~prev);
      end
   end

endmodule : clk_activity

// ===== framer_loopback.sv
module framer_loopback
   import framer_ctrl_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_soft_reset,
   input wire logic i_line_loop,
   input wire logic i_digital_loop,
   input wire logic i_rja_bypass,
   input wire logic i_payload_sel,
   input wire logic i_rx_clock_master,
   input wire logic i_line_rx_clock,
   input wire logic i_line_rx_data,
   input wire logic i_rja_clock,
   input wire logic i_rja_data,
   input wire logic i_core_tx_clock,
   input wire logic i_core_tx_data,
   input wire logic [7:0] i_es_rx_pay,
   input wire logic [7:0] i_rx_pay,
   input wire logic [7:0] i_core_tx_pay,
   output logic o_line_tx_clock,
   output logic o_line_tx_data,
   output logic o_core_rx_clock,
   output logic o_core_rx_data,
   output logic [7:0] o_tx_pay
);

   // line side transmit: own transmit path or looped receive path
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_line_tx_clock <= 1'b0;
         o_line_tx_data <= 1'b0;
      end else if (i_soft_reset) begin
         o_line_tx_clock <= 1'b0;
         o_line_tx_data <= 1'b0;
      end else if (i_line_loop) begin
         o_line_tx_clock <= i_rja_bypass ? i_line_rx_clock : i_rja_clock;
         o_line_tx_data <= i_rja_bypass ? i_line_rx_data : i_rja_data;
      end else begin
         o_line_tx_clock <= i_core_tx_clock;
         o_line_tx_data <= i_core_tx_data;
      end
   end

   // receive side into the framer core: line or looped transmit path
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_core_rx_clock <= 1'b0;
         o_core_rx_data <= 1'b0;
      end else if (i_soft_reset) begin
         o_core_rx_clock <= 1'b0;
         o_core_rx_data <= 1'b0;
      end else begin
         o_core_rx_clock <= i_digital_loop ? i_core_tx_clock : i_line_rx_clock;
         o_core_rx_data <= i_digital_loop ? i_core_tx_data : i_line_rx_data;
      end
   end

   // payload: selected slots take the received slot, the rest pass intact
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_tx_pay <= 8'h00;
      end else if (i_soft_reset) begin
         o_tx_pay <= 8'h00;
      end else if (i_payload_sel) begin
         o_tx_pay <= i_rx_clock_master ? i_es_rx_pay : i_rx_pay;
      end else begin
         o_tx_pay <= i_core_tx_pay;
      end
   end

endmodule : framer_loopback

// ===== framer_ctrl_monitor.sv
module framer_ctrl_monitor
   import framer_ctrl_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic o_wb_ack,
   input wire logic o_irq_n,
   input wire logic o_t1_e1_select,
   input wire logic [NUM_FRAMERS*8-1:0] i_src_rx,
   input wire logic [NUM_FRAMERS*8-1:0] i_src_tx,
   input wire logic [NUM_FRAMERS*8-1:0] o_ja_n1,
   input wire logic [NUM_FRAMERS-1:0] o_framer_reset
);
   timeunit 1ns;
   timeprecision 1ns;
   // a bus request still waiting for its answer
   sequence s_req;
      i_wb_cyc && i_wb_stb && !o_wb_ack;
   endsequence
   default clocking @(posedge i_clk_sys);
   endclocking
   default disable iff (i_reset);
   a_ack_follows: assert property (s_req |=> o_wb_ack) else $error("ack late");
   a_ack_single: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
   a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb)) else $error("ack unasked");
   a_irq_raise: assert property ((|i_src_rx) [*4] |-> !o_irq_n)
      else $error("irq not low");
   a_irq_idle: assert property ((i_src_rx == 64'h0 && i_src_tx == 64'h0) [*4] |-> o_irq_n)
      else $error("irq not high");
   a_reset_vals: assert property (disable iff (1'b0) i_reset && $past(i_reset)
      |-> o_t1_e1_select && o_ja_n1[7:0] == 8'h2F) else $error("bad reset value");
   a_soft_pulse: assert property (|o_framer_reset |=> o_framer_reset == 8'h00)
      else $error("soft pulse long");
   a_div_cause: assert property ($changed(o_ja_n1) |-> $past(o_wb_ack && i_wb_we)
      || $past(o_wb_ack && i_wb_we, 2) || $past(|o_framer_reset)) else $error("divisor moved");
endmodule : framer_ctrl_monitor
bind framer_irq_loopback_ctrl framer_ctrl_monitor mon (.*);

// ===== host_model.sv
module host_model (
   input wire logic i_clk,
   input wire logic i_ack,
   input wire logic [31:0] i_rdat,
   output logic o_cyc = 1'b0,
   output logic o_stb = 1'b0,
   output logic o_we = 1'b0,
   output logic [10:0] o_adr = 11'h000,
   output logic [3:0] o_sel = 4'hF,
   output logic [31:0] o_dat = 32'h0
);
   timeunit 1ns;
   timeprecision 1ns;
   // one classic cycle; released address and data lines are scrambled, not left holding
   task automatic xfer(input logic w, input logic [10:0] a, input logic [7:0] d, output logic [7:0] q);
      o_cyc <= 1'b1;
      o_stb <= 1'b1;
      o_we <= w;
      o_adr <= a;
      o_dat <= {24'h0, d};
      do @(posedge i_clk); while (i_ack !== 1'b1);
      q = i_rdat[7:0];
      o_cyc <= 1'b0;
      o_stb <= 1'b0;
      o_adr <= ~a;
      o_dat <= ~{24'h0, d};
      @(posedge i_clk);
   endtask : xfer
endmodule : host_model

// ===== testbench.sv
module testbench
   import framer_ctrl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk_sys = 1'b0;
   logic i_reset = 1'b1;
   logic i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack, o_irq_n, o_t1_e1_select;
   logic [10:0] i_wb_adr;
   logic [3:0] i_wb_sel;
   logic [31:0] i_wb_dat, o_wb_dat;
   logic i_crystal_clock = 1'b0;
   logic [63:0] i_src_rx = '0, i_src_tx = '0, i_es_rx_pay = '0, i_rx_pay = '0, i_core_tx_pay = '0;
   logic [7:0] i_tx_sys_clock_a = '0, i_tx_sys_clock_b = '0, i_rx_sys_clock = '0, i_line_rx_clock = '0;
   logic [7:0] i_line_rx_data = '0, i_rja_clock = '0, i_rja_data = '0, i_core_tx_clock = '0, i_core_tx_data = '0;
   logic [39:0] i_tx_slot = '0, o_line_cfg;
   logic [63:0] o_tx_pay, o_ja_n1, o_ja_n2;
   logic [7:0] o_line_tx_clock, o_line_tx_data, o_core_rx_clock, o_core_rx_data, o_framer_reset, q;
   logic [3:0] cnt = 4'h0;
   int failures = 0;
   int total_checks = 0;
   framer_irq_loopback_ctrl dut (.*);
   host_model host (.i_clk(i_clk_sys), .i_ack(o_wb_ack), .i_rdat(o_wb_dat), .o_cyc(i_wb_cyc), .o_stb(i_wb_stb),
      .o_we(i_wb_we), .o_adr(i_wb_adr), .o_sel(i_wb_sel), .o_dat(i_wb_dat));
   // 20 MHz system clock
   always #25 i_clk_sys = ~i_clk_sys;
   // slow pin clocks feeding the activity monitor
   always @(posedge i_clk_sys) begin
      cnt <= cnt + 4'h1;
      i_crystal_clock <= cnt[1];
      i_tx_sys_clock_a <= {8{cnt[1]}};
      i_tx_sys_clock_b <= {8{cnt[2]}};
      i_rx_sys_clock <= {8{cnt[1]}};
      i_line_rx_clock <= {8{cnt[2]}};
      i_line_rx_data <= {8{cnt[3]}};
   end
   task automatic w(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask : w
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         failures++;
         $display("[ERR] %s exp %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wr(input logic [10:0] a, input logic [7:0] d);
      host.xfer(1'b1, a, d, q);
   endtask : wr
   task automatic rc(input string n, input logic [10:0] a, input logic [7:0] e);
      host.xfer(1'b0, a, 8'h00, q);
      chk(n, {24'h0, q}, {24'h0, e});
   endtask : rc
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish
   // watchdog against a hung bus
   initial begin
      w(3000);
      failures++;
      tally_and_finish();
   end
   // main sequence
   initial begin
      w(16);
      i_reset <= 1'b0;
      w(1);
      rc("mode", 11'h400, 8'h01);
      rc("n1", 11'h078, 8'h2F);
      rc("cfg", 11'h07A, 8'h00);
      chk("n2o", o_ja_n2[15:8], 8'h2F);
      chk("cfgo", o_line_cfg[4:0], 5'h00);
      rc("free", 11'h07F, 8'h00);
      rc("act", 11'h027, 8'h1F);
      w(6);
      rc("act2", 11'h027, 8'h1F);
      i_src_rx[31:24] <= 8'h80;
      i_src_tx[31:24] <= 8'h42;
      w(5);
      chk("irq", o_irq_n, 1'b0);
      rc("sum", 11'h00E, 8'h08);
      rc("srx", 11'h188, 8'h80);
      rc("stx", 11'h189, 8'h40);
      i_src_rx <= '0;
      i_src_tx <= '0;
      w(5);
      chk("irq", o_irq_n, 1'b1);
      wr(11'h00A, 8'h10);
      for (int v = 0; v < 2; v++) begin
         i_rja_data <= {7'h0, v[0]};
         i_rja_clock <= {7'h0, v[0]};
         w(4);
         chk("ltx", o_line_tx_data[0], v[0]);
         chk("ltc", o_line_tx_clock[0], v[0]);
      end
      // bypass: line data from the pin counter, seen four edges later
      i_rja_data <= 8'h00;
      wr(11'h00A, 8'h30);
      w(2);
      while (cnt != 4'hC) w(1);
      chk("byp", o_line_tx_data[0], 1'b1);
      wr(11'h00A, 8'h04);
      for (int v = 0; v < 2; v++) begin
         i_core_tx_data <= {7'h0, v[0]};
         i_core_tx_clock <= {7'h0, v[0]};
         w(4);
         chk("crx", o_core_rx_data[0], v[0]);
         chk("crc", o_core_rx_clock[0], v[0]);
         chk("dtx", o_line_tx_data[0], v[0]);
      end
      wr(11'h030, 8'h01);
      wr(11'h042, 8'h04);
      i_rx_pay <= {8{8'hA5}};
      i_core_tx_pay <= {8{8'h3C}};
      for (int s = 1; s < 3; s++) begin
         i_tx_slot <= {8{s[4:0]}};
         w(4);
         chk("pay", o_tx_pay[7:0], (s == 2) ? 8'hA5 : 8'h3C);
      end
      wr(11'h07A, 8'h10);
      i_es_rx_pay <= {8{8'h5A}};
      w(4);
      chk("pes", o_tx_pay[7:0], 8'h5A);
      chk("cfgm", o_line_cfg[4:0], 5'h10);
      wr(11'h030, 8'h00);
      w(4);
      chk("pay", o_tx_pay[7:0], 8'h3C);
      wr(11'h078, 8'h11);
      rc("n1w", 11'h078, 8'h11);
      wr(11'h00D, 8'h01);
      w(3);
      rc("n1r", 11'h078, 8'h2F);
      rc("loop", 11'h00A, 8'h00);
      chk("cfgs", o_line_cfg[4:0], 5'h00);
      wr(11'h400, 8'h00);
      w(1);
      chk("sel", o_t1_e1_select, 1'b0);
      i_src_tx[15:8] <= 8'hFF;
      i_src_rx[15:8] <= 8'h24;
      w(4);
      rc("e1tx", 11'h086, 8'hBF);
      rc("e1rx", 11'h085, 8'h24);
      rc("e1sum", 11'h08B, 8'h02);
      tally_and_finish();
   end
endmodule : testbench
